// file: core/str_fifo.sv
// block buffer fifo, flip-flop storage
// assumes DEPTH is a power of two; pointers wrap freely
`timescale 1ns/100ps
module str_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  str_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic full_r;
  logic empty_r;
  logic push;
  logic pop;
  assign push = q.push_valid && !full_r;
  assign pop = q.pop_ready && !empty_r;
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  assign q.push_ready = !full_r;
  assign q.pop_valid = !empty_r;
  assign q.pop_data = mem_r[rp_r];
  // ************************************************************
  // storage and pointers
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wp_r] <= q.push_data;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_nxt;
      // flags registered so ready never depends on pop
      full_r <= (cnt_nxt == FULL);
      empty_r <= (cnt_nxt == '0);
    end
  end
endmodule : str_fifo

// file: core/str_fifo_if.sv
// fill and drain signals of one buffer fifo
// assumes one filler and one drainer on the same clock
`timescale 1ns/100ps
interface str_fifo_if #(parameter int W = 8);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport fifo(input push_valid, push_data, pop_ready,
               output push_ready, pop_valid, pop_data);
  modport user(output push_valid, push_data, pop_ready,
               input push_ready, pop_valid, pop_data);
endinterface : str_fifo_if

// file: core/str_map.svh
// constants for the streaming tape recovery block
// assumes a single include per compile unit, guarded below
`ifndef STR_MAP_SVH
`define STR_MAP_SVH
// ************************************************************
// timing, in mils of tape (0.001 inch)
// ************************************************************
`define STR_GAP_EXT_MILS 300
`define STR_IRG_MILS 13
// ************************************************************
// limits and widths
// ************************************************************
`define STR_RETRY_MAX 5'h10
`define STR_STAT_LAST 3'h5
`define STR_CNT_W 8
`define STR_ADDR_RST 8'h00
`define STR_TMR_W 16
`endif

// file: core/str_pkg.sv
// state types for the streaming tape recovery block
// assumes str_map.svh holds the numeric constants
package str_pkg;
  typedef enum logic [5:0] {
    W_IDLE = 6'b00_0001,
    W_BUSY = 6'b00_0010,
    W_GAP = 6'b00_0100,
    W_EXT = 6'b00_1000,
    W_OVR = 6'b01_0000,
    W_ERR = 6'b10_0000
  } str_wr_st_t;
  typedef enum logic [4:0] {
    R_IDLE = 5'b0_0001,
    R_RUN = 5'b0_0010,
    R_UR = 5'b0_0100,
    R_SEEK = 5'b0_1000,
    R_END = 5'b1_0000
  } str_rd_st_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_PUT = 3'b010,
    S_DROP = 3'b100
  } str_st_st_t;
endpackage : str_pkg

// file: core/str_sat_cnt.sv
// saturating statistics counter
// assumes inc is a one-cycle pulse per event
`timescale 1ns/100ps
module str_sat_cnt #(
  parameter int W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic inc_i,
  output logic [W-1:0] cnt_o
);
  logic [W-1:0] cnt_r;
  assign cnt_o = cnt_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (inc_i && cnt_r != '1) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  property p_hold_max;
    @(posedge sys_clk_i) disable iff (rst_i)
    (cnt_r == '1) |=> (cnt_r == '1);
  endproperty
  a_hold_max: assert property (p_hold_max)
    else $error("statistics counter wrapped");
endmodule : str_sat_cnt

// file: core/str_top.sv
// streaming tape error recovery: gap extension, rewrite on
// read-after-write failure, read underrun and soft retry
// assumes the drive pulses its events one cycle each
//
// Function
// - stretch write gap by 0.3 in when starved
// - count each gap extension exactly once
// - buffer arriving ends extension, write at once
// - extension ran out: write buffer overrun
// - verify each block; rewrite on crc failure
// - next block written before previous verified
// - sixteen rewrites then abort with data error
// - counter of automatically rewritten blocks
// - one spare buffer held during reads
// - no buffer: stop, back up, wait, reseek
// - count every read underrun recovery
// - read error: reread block up to sixteen
// - give up: transfer, flag wrong block, end
// - soft retries counted; write rewrites not
// - block address byte orders read blocks
// - bad address sequence retried like errors
// - six status bytes by ready/request handshake
`timescale 1ns/100ps
`include "str_map.svh"
module str_top #(
  parameter int DW = 8,
  parameter int DEPTH = 32,
  parameter int CYC_PER_MIL = 10
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic host_wr_valid_i,
  input wire logic [DW-1:0] host_wr_data_i,
  output logic host_wr_ready_o,
  output logic host_rd_valid_o,
  output logic [DW-1:0] host_rd_data_o,
  output logic host_rd_wrong_o,
  input wire logic host_rd_ready_i,
  input wire logic wr_active_i,
  input wire logic rd_active_i,
  output logic tape_wr_go_o,
  output logic [DW-1:0] tape_wr_data_o,
  output logic [7:0] tape_wr_addr_o,
  input wire logic tape_wr_done_i,
  input wire logic tape_raw_i,
  input wire logic tape_raw_bad_i,
  input wire logic tape_blk_i,
  input wire logic [DW-1:0] tape_blk_data_i,
  input wire logic [7:0] tape_blk_addr_i,
  input wire logic tape_blk_crc_err_i,
  output logic tape_reread_o,
  output logic tape_stop_o,
  output logic tape_backup_o,
  output logic tape_start_o,
  input wire logic stat_cmd_i,
  input wire logic stat_req_i,
  output logic stat_dirc_o,
  output logic stat_rdy_o,
  output logic [7:0] stat_data_o,
  output logic wr_ovr_o,
  output logic wr_err_o,
  output logic rd_err_o
);
  localparam int TW = `STR_TMR_W;
  localparam int IRG_CYC = `STR_IRG_MILS * CYC_PER_MIL;
  localparam int EXT_CYC = `STR_GAP_EXT_MILS * CYC_PER_MIL;
  localparam logic [TW-1:0] IRG_LAST = TW'(IRG_CYC - 1);
  localparam logic [TW-1:0] EXT_LAST = TW'(EXT_CYC - 1);
  str_fifo_if #(.W(DW)) wf();
  str_fifo_if #(.W(DW + 1)) rf();
  str_fifo #(.W(DW), .DEPTH(DEPTH)) u_wr_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .q(wf.fifo)
  );
  str_fifo #(.W(DW + 1), .DEPTH(DEPTH)) u_rd_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .q(rf.fifo)
  );
  // ************************************************************
  // statistics counters: gap, rewrite, underrun, soft retry
  // ************************************************************
  logic [3:0] cnt_inc;
  logic [`STR_CNT_W-1:0] cnt_val [4];
  for (genvar i = 0; i < 4; i++) begin : g_cnt
    str_sat_cnt #(.W(`STR_CNT_W)) u_cnt (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .inc_i(cnt_inc[i]),
      .cnt_o(cnt_val[i])
    );
  end
  // ************************************************************
  // write channel
  // ************************************************************
  str_pkg::str_wr_st_t wst_r;
  logic [TW-1:0] tmr_r;
  logic [DW-1:0] pend_d_r [2];
  logic [7:0] pend_a_r [2];
  logic [1:0] pend_cnt_r;
  logic [7:0] wr_addr_r;
  logic [4:0] wr_rty_r;
  logic redo_r;
  logic fail_hd_r;
  logic wr_ovr_r;
  logic wr_err_r;
  logic tape_wr_go_r;
  logic [DW-1:0] tape_wr_data_r;
  logic [7:0] tape_wr_addr_r;
  logic gap_end;
  logic ext_end;
  logic avail;
  logic want;
  logic start;
  logic start_new;
  logic raw_ev;
  logic raw_bad;
  logic raw_good;
  logic give_up;
  assign gap_end = (tmr_r == IRG_LAST);
  assign ext_end = (tmr_r == EXT_LAST);
  // at most two blocks in flight between write and read heads
  assign avail = redo_r || (wf.pop_valid && pend_cnt_r != 2'h2);
  assign want = wr_active_i && (wst_r == str_pkg::W_IDLE ||
    wst_r == str_pkg::W_EXT || (wst_r == str_pkg::W_GAP && gap_end));
  // a verify pulse defers the start one cycle to keep queue order
  assign start = want && avail && !tape_raw_i;
  assign start_new = start && !redo_r;
  assign raw_ev = tape_raw_i && wr_active_i && pend_cnt_r != 2'h0;
  assign raw_bad = raw_ev && tape_raw_bad_i;
  assign raw_good = raw_ev && !tape_raw_bad_i;
  assign give_up = raw_bad && wr_rty_r == `STR_RETRY_MAX;
  assign wf.push_valid = host_wr_valid_i;
  assign wf.push_data = host_wr_data_i;
  assign wf.pop_ready = start_new;
  assign host_wr_ready_o = wf.push_ready;
  assign cnt_inc[0] = wr_active_i && !give_up && !avail &&
    wst_r == str_pkg::W_GAP && gap_end;
  assign cnt_inc[1] = raw_bad && !give_up;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !wr_active_i) begin
      wst_r <= str_pkg::W_IDLE;
      tmr_r <= '0;
    end else if (give_up) begin
      wst_r <= str_pkg::W_ERR;
    end else begin
      unique case (wst_r)
        str_pkg::W_IDLE: begin
          if (start) begin
            wst_r <= str_pkg::W_BUSY;
          end
        end
        str_pkg::W_BUSY: begin
          tmr_r <= '0;
          if (tape_wr_done_i) begin
            wst_r <= str_pkg::W_GAP;
          end
        end
        str_pkg::W_GAP: begin
          if (!gap_end) begin
            tmr_r <= tmr_r + 1'b1;
          end else if (start) begin
            wst_r <= str_pkg::W_BUSY;
          end else if (!avail) begin
            wst_r <= str_pkg::W_EXT;
            tmr_r <= '0;
          end
        end
        str_pkg::W_EXT: begin
          if (start) begin
            wst_r <= str_pkg::W_BUSY;
          end else if (ext_end) begin
            wst_r <= str_pkg::W_OVR;
          end else begin
            tmr_r <= tmr_r + 1'b1;
          end
        end
        str_pkg::W_OVR, str_pkg::W_ERR: begin
          wst_r <= wst_r;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tape_wr_go_r <= 1'b0;
      tape_wr_data_r <= '0;
      tape_wr_addr_r <= `STR_ADDR_RST;
    end else begin
      tape_wr_go_r <= start;
      if (start) begin
        tape_wr_data_r <= redo_r ? pend_d_r[pend_cnt_r[1]] : wf.pop_data;
        tape_wr_addr_r <= redo_r ? pend_a_r[pend_cnt_r[1]] :
          wr_addr_r;
      end
    end
  end
  // unverified blocks, oldest first
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !wr_active_i) begin
      pend_cnt_r <= 2'h0;
      wr_addr_r <= `STR_ADDR_RST;
    end else if (raw_good) begin
      pend_d_r[0] <= pend_d_r[1];
      pend_a_r[0] <= pend_a_r[1];
      pend_cnt_r <= pend_cnt_r - 1'b1;
    end else if (start_new) begin
      pend_d_r[pend_cnt_r[0]] <= wf.pop_data;
      pend_a_r[pend_cnt_r[0]] <= wr_addr_r;
      pend_cnt_r <= pend_cnt_r + 1'b1;
      wr_addr_r <= wr_addr_r + 1'b1;
    end else if (raw_bad && pend_cnt_r == 2'h2) begin
      pend_d_r[0] <= pend_d_r[1];
      pend_a_r[0] <= pend_a_r[1];
      pend_d_r[1] <= pend_d_r[0];
      pend_a_r[1] <= pend_a_r[0];
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !wr_active_i) begin
      redo_r <= 1'b0;
      wr_rty_r <= 5'h00;
      fail_hd_r <= 1'b1;
    end else if (raw_bad && !give_up) begin
      redo_r <= 1'b1;
      wr_rty_r <= wr_rty_r + 1'b1;
      fail_hd_r <= (pend_cnt_r == 2'h1);
    end else begin
      // an older block passing keeps the failing count
      if (raw_good) begin
        wr_rty_r <= fail_hd_r ? 5'h00 : wr_rty_r;
        fail_hd_r <= 1'b1;
      end
      if (start) begin
        redo_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_ovr_r <= 1'b0;
      wr_err_r <= 1'b0;
    end else begin
      if (wst_r == str_pkg::W_IDLE && wr_active_i) begin
        wr_ovr_r <= 1'b0;
        wr_err_r <= 1'b0;
      end
      if (wst_r == str_pkg::W_EXT && !start && ext_end &&
          wr_active_i && !give_up) begin
        wr_ovr_r <= 1'b1;
      end
      if (give_up && wr_active_i) begin
        wr_err_r <= 1'b1;
      end
    end
  end
  // ************************************************************
  // read channel
  // ************************************************************
  str_pkg::str_rd_st_t rst_r;
  logic [7:0] exp_r;
  logic [4:0] rd_rty_r;
  logic last_good_r;
  logic seq_err_r;
  logic wrong_r;
  logic rd_err_r;
  logic [7:0] fail_addr_r;
  logic [2:0] pulse_r;
  logic rd_take;
  logic b_good;
  logic b_dup;
  logic b_bad;
  logic b_retry;
  logic b_quit;
  logic b_ur;
  assign rd_take = tape_blk_i && rd_active_i &&
    (rst_r == str_pkg::R_RUN ||
     (rst_r == str_pkg::R_SEEK && tape_blk_addr_i == exp_r));
  assign b_good = !tape_blk_crc_err_i && tape_blk_addr_i == exp_r;
  // only the previous address (exp_r - 1) is a rewritten duplicate, skipped silently
  assign b_dup = !tape_blk_crc_err_i &&
    tape_blk_addr_i == exp_r - 1'b1;
  assign b_bad = !b_good && !b_dup;
  assign b_retry = rd_take && b_bad && rd_rty_r < `STR_RETRY_MAX;
  assign b_quit = rd_take && b_bad && rd_rty_r == `STR_RETRY_MAX;
  // last free slot is the reserve; full means it is used up
  assign b_ur = rd_take && b_good && !rf.push_ready;
  assign rf.push_valid = rd_take &&
    ((b_good && rf.push_ready) || b_quit);
  assign rf.push_data = {b_quit && tape_blk_addr_i != exp_r,
    tape_blk_data_i};
  assign rf.pop_ready = host_rd_ready_i;
  assign host_rd_valid_o = rf.pop_valid;
  assign host_rd_data_o = rf.pop_data[DW-1:0];
  assign host_rd_wrong_o = rf.pop_data[DW];
  assign cnt_inc[2] = b_ur;
  assign cnt_inc[3] = b_retry;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !rd_active_i) begin
      rst_r <= str_pkg::R_IDLE;
      exp_r <= `STR_ADDR_RST;
      rd_rty_r <= 5'h00;
      last_good_r <= 1'b0;
    end else begin
      unique case (rst_r)
        str_pkg::R_IDLE: begin
          rst_r <= str_pkg::R_RUN;
        end
        str_pkg::R_RUN, str_pkg::R_SEEK: begin
          if (b_ur) begin
            rst_r <= str_pkg::R_UR;
          end else if (rd_take && b_good) begin
            rst_r <= str_pkg::R_RUN;
            exp_r <= exp_r + 1'b1;
            rd_rty_r <= 5'h00;
            last_good_r <= 1'b1;
          end else if (b_retry) begin
            rd_rty_r <= rd_rty_r + 1'b1;
            last_good_r <= 1'b0;
          end else if (b_quit) begin
            rst_r <= str_pkg::R_END;
          end
        end
        str_pkg::R_UR: begin
          if (rf.push_ready) begin
            rst_r <= str_pkg::R_SEEK;
          end
        end
        str_pkg::R_END: begin
          rst_r <= str_pkg::R_END;
        end
      endcase
    end
  end
  // reread, stop+backup, restart pulses
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pulse_r <= 3'h0;
    end else begin
      pulse_r[0] <= b_retry;
      pulse_r[1] <= b_ur;
      pulse_r[2] <= rd_active_i && rst_r == str_pkg::R_UR &&
        rf.push_ready;
    end
  end
  assign tape_reread_o = pulse_r[0];
  assign tape_stop_o = pulse_r[1];
  assign tape_backup_o = pulse_r[1];
  assign tape_start_o = pulse_r[2];
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      seq_err_r <= 1'b0;
      wrong_r <= 1'b0;
      rd_err_r <= 1'b0;
      fail_addr_r <= `STR_ADDR_RST;
    end else begin
      if (rst_r == str_pkg::R_IDLE && rd_active_i) begin
        seq_err_r <= 1'b0;
        wrong_r <= 1'b0;
        rd_err_r <= 1'b0;
      end
      if (rd_take && last_good_r && !tape_blk_crc_err_i &&
          b_bad) begin
        seq_err_r <= 1'b1;
      end
      if (b_quit) begin
        rd_err_r <= 1'b1;
        wrong_r <= tape_blk_addr_i != exp_r;
        fail_addr_r <= exp_r;
      end
    end
  end
  // ************************************************************
  // status readout
  // ************************************************************
  str_pkg::str_st_st_t sst_r;
  logic [2:0] idx_r;
  logic [7:0] byte_nxt;
  logic [2:0] idx_nxt;
  logic stat_dirc_r;
  logic stat_rdy_r;
  logic [7:0] stat_data_r;
  assign idx_nxt = (sst_r == str_pkg::S_IDLE) ? 3'h0 : idx_r + 1'b1;
  always_comb begin
    unique case (idx_nxt)
      3'h0: byte_nxt = cnt_val[0];
      3'h1: byte_nxt = cnt_val[1];
      3'h2: byte_nxt = cnt_val[2];
      3'h3: byte_nxt = cnt_val[3];
      3'h4: byte_nxt = {3'h0, seq_err_r, wrong_r, rd_err_r,
                        wr_err_r, wr_ovr_r};
      default: byte_nxt = fail_addr_r;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sst_r <= str_pkg::S_IDLE;
      idx_r <= 3'h0;
      stat_dirc_r <= 1'b0;
      stat_rdy_r <= 1'b0;
      stat_data_r <= 8'h00;
    end else begin
      unique case (sst_r)
        str_pkg::S_IDLE: begin
          if (stat_cmd_i) begin
            sst_r <= str_pkg::S_PUT;
            idx_r <= idx_nxt;
            stat_dirc_r <= 1'b1;
            stat_data_r <= byte_nxt;
            stat_rdy_r <= 1'b1;
          end
        end
        str_pkg::S_PUT: begin
          if (stat_req_i) begin
            sst_r <= str_pkg::S_DROP;
            stat_rdy_r <= 1'b0;
          end
        end
        str_pkg::S_DROP: begin
          if (!stat_req_i && idx_r == `STR_STAT_LAST) begin
            sst_r <= str_pkg::S_IDLE;
            stat_dirc_r <= 1'b0;
          end else if (!stat_req_i) begin
            sst_r <= str_pkg::S_PUT;
            idx_r <= idx_nxt;
            stat_data_r <= byte_nxt;
            stat_rdy_r <= 1'b1;
          end
        end
      endcase
    end
  end
  assign stat_dirc_o = stat_dirc_r;
  assign stat_rdy_o = stat_rdy_r;
  assign stat_data_o = stat_data_r;
  assign tape_wr_go_o = tape_wr_go_r;
  assign tape_wr_data_o = tape_wr_data_r;
  assign tape_wr_addr_o = tape_wr_addr_r;
  assign wr_ovr_o = wr_ovr_r;
  assign wr_err_o = wr_err_r;
  assign rd_err_o = rd_err_r;
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_ext_len;
    (wst_r == str_pkg::W_EXT) |-> (tmr_r <= EXT_LAST);
  endproperty
  a_ext_len: assert property (p_ext_len)
    else $error("gap extension too long");
  property p_gap_once;
    cnt_inc[0] |=> (wst_r == str_pkg::W_EXT) && !cnt_inc[0];
  endproperty
  a_gap_once: assert property (p_gap_once)
    else $error("gap extension miscounted");
  property p_ext_cut;
    (wst_r == str_pkg::W_EXT && avail && !tape_raw_i && wr_active_i)
      |=> tape_wr_go_o && wst_r == str_pkg::W_BUSY;
  endproperty
  a_ext_cut: assert property (p_ext_cut)
    else $error("extension not ended by buffer");
  property p_overrun;
    (wst_r == str_pkg::W_EXT && !avail && ext_end && wr_active_i &&
     !give_up) |=> wr_ovr_o && wst_r == str_pkg::W_OVR;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not reported");
  property p_redo;
    (raw_bad && !give_up) |=> redo_r && !tape_wr_go_o;
  endproperty
  a_redo: assert property (p_redo)
    else $error("failed block not queued for rewrite");
  property p_give_up;
    give_up |=> wr_err_o && wst_r == str_pkg::W_ERR;
  endproperty
  a_give_up: assert property (p_give_up)
    else $error("rewrite limit not enforced");
  property p_underrun;
    b_ur |=> tape_stop_o && tape_backup_o && rst_r == str_pkg::R_UR;
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("underrun not handled");
  property p_soft_only_read;
    cnt_inc[3] |-> tape_blk_i && !raw_ev ##1 tape_reread_o;
  endproperty
  a_soft_only_read: assert property (p_soft_only_read)
    else $error("soft retry miscounted");
  property p_quit;
    b_quit |=> rd_err_o && rst_r == str_pkg::R_END;
  endproperty
  a_quit: assert property (p_quit)
    else $error("retry limit not enforced");
  property p_stat_hs;
    (stat_rdy_o && stat_req_i) |=> !stat_rdy_o && stat_dirc_o;
  endproperty
  a_stat_hs: assert property (p_stat_hs)
    else $error("status handshake broken");
  c_ext: cover property (cnt_inc[0] ##[1:400] tape_wr_go_o);
  c_rewrite: cover property (cnt_inc[1] ##[1:50] tape_wr_go_o);
  c_underrun: cover property (b_ur ##[1:200] tape_start_o);
  c_status: cover property ($fell(stat_dirc_o));
endmodule : str_top

// file: testbench/str_host_model.sv
// host model: fills write fifo, drains read fifo, reads status
// assumes the block clock; drives 1 ns after each edge
`timescale 1ns/100ps
module str_host_model (
  input wire logic clk_i,
  input wire logic wr_rdy_i,
  input wire logic rd_vld_i,
  input wire logic [7:0] rd_dat_i,
  input wire logic rd_wrg_i,
  input wire logic st_rdy_i,
  input wire logic [7:0] st_dat_i,
  output logic wr_vld_o,
  output logic [7:0] wr_dat_o,
  output logic rd_rdy_o,
  output logic st_cmd_o,
  output logic st_req_o
);
  logic [7:0] sb [6];
  int n;
  initial begin
    {wr_vld_o, wr_dat_o, rd_rdy_o, st_cmd_o, st_req_o} = '0;
  end
  // ****
  // host tasks, n reaches 99 on a hang
  // ****
  task automatic step;
    @(posedge clk_i);
    #1;
    n++;
  endtask : step
  task automatic push(input logic [7:0] d);
    n = 0;
    wr_vld_o = 1'b1;
    wr_dat_o = d;
    do @(posedge clk_i); while (wr_rdy_i !== 1'b1 && ++n < 99);
    #1 wr_vld_o = 1'b0;
    step;
  endtask : push
  // ready only while asked, so the read side can stall
  task automatic pop(output logic [7:0] d, output logic w);
    n = 0;
    rd_rdy_o = 1'b1;
    do @(posedge clk_i); while (rd_vld_i !== 1'b1 && ++n < 99);
    d = rd_dat_i;
    w = rd_wrg_i;
    #1 rd_rdy_o = 1'b0;
    step;
  endtask : pop
  task automatic status;
    n = 0;
    st_cmd_o = 1'b1;
    step;
    st_cmd_o = 1'b0;
    for (int i = 0; i < 6; i++) begin
      while (st_rdy_i !== 1'b1 && n < 99) step;
      sb[i] = st_dat_i;
      st_req_o = 1'b1;
      while (st_rdy_i !== 1'b0 && n < 99) step;
      st_req_o = 1'b0;
    end
  endtask : status
endmodule : str_host_model

// file: testbench/str_top_bench.sv
// bench for the tape recovery block: gap, rewrite, read, status
// assumes the core files and the host model compile first
`timescale 1ns/100ps
module str_top_bench;
  logic sys_clk_i, rst_i, host_wr_valid_i, host_wr_ready_o, w;
  logic host_rd_valid_o, host_rd_wrong_o, host_rd_ready_i;
  logic wr_active_i, rd_active_i, tape_wr_go_o, tape_wr_done_i;
  logic tape_raw_i, tape_raw_bad_i, tape_blk_i, tape_blk_crc_err_i;
  logic tape_reread_o, tape_stop_o, tape_backup_o, tape_start_o;
  logic stat_cmd_i, stat_req_i, stat_dirc_o, stat_rdy_o;
  logic wr_ovr_o, wr_err_o, rd_err_o;
  logic [7:0] host_wr_data_i, host_rd_data_o, tape_wr_data_o, d;
  logic [7:0] tape_wr_addr_o, tape_blk_data_i, tape_blk_addr_i;
  logic [7:0] stat_data_o;
  logic [1:0] s;
  int num_errors, n_tests, n, k;
  // one cycle per mil keeps the 300 mil extension short
  str_top #(.CYC_PER_MIL(1)) str_top_inst (
    .sys_clk_i, .rst_i, .host_wr_valid_i, .host_wr_data_i,
    .host_wr_ready_o, .host_rd_valid_o, .host_rd_data_o,
    .host_rd_wrong_o, .host_rd_ready_i, .wr_active_i, .rd_active_i,
    .tape_wr_go_o, .tape_wr_data_o, .tape_wr_addr_o, .tape_wr_done_i,
    .tape_raw_i, .tape_raw_bad_i, .tape_blk_i, .tape_blk_data_i,
    .tape_blk_addr_i, .tape_blk_crc_err_i, .tape_reread_o,
    .tape_stop_o, .tape_backup_o, .tape_start_o, .stat_cmd_i,
    .stat_req_i, .stat_dirc_o, .stat_rdy_o, .stat_data_o,
    .wr_ovr_o, .wr_err_o, .rd_err_o
  );
  str_host_model str_host_model_inst (
    .clk_i(sys_clk_i), .wr_rdy_i(host_wr_ready_o),
    .rd_vld_i(host_rd_valid_o), .rd_dat_i(host_rd_data_o),
    .rd_wrg_i(host_rd_wrong_o), .st_rdy_i(stat_rdy_o),
    .st_dat_i(stat_data_o), .wr_vld_o(host_wr_valid_i),
    .wr_dat_o(host_wr_data_i), .rd_rdy_o(host_rd_ready_i),
    .st_cmd_o(stat_cmd_i), .st_req_o(stat_req_i)
  );
  // ****
  // helpers
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic hang(input logic b);
    if (b) begin
      num_errors++;
      results;
    end
  endtask : hang
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk_i);
    #1;
  endtask : cyc
  // one cycle of drive events; a spare cycle avoids double drives
  task automatic ev(input logic dn, rw, bd, bk, cr, input logic [7:0] a);
    {tape_wr_done_i, tape_raw_i, tape_raw_bad_i} = {dn, rw, bd};
    {tape_blk_i, tape_blk_crc_err_i, tape_blk_addr_i} = {bk, cr, a};
    tape_blk_data_i = a;
    cyc(1);
    s = {tape_stop_o & tape_backup_o, tape_reread_o};
    {tape_wr_done_i, tape_raw_i, tape_blk_i} = '0;
    cyc(1);
  endtask : ev
  task automatic wt(input int sel, lim);
    n = 0;
    while (n < lim && !(sel == 0 ? tape_wr_go_o === 1'b1 :
        sel == 1 ? tape_start_o === 1'b1 : wr_ovr_o === 1'b1)) begin
      cyc(1);
      n++;
    end
    hang(n == lim || str_host_model_inst.n >= 99);
  endtask : wt
  // ****
  // scenarios
  // ****
  task automatic t_gap;
    wr_active_i = 1'b1;
    str_host_model_inst.push(8'h5a);
    wt(0, 20);
    chk("wr_data", tape_wr_data_o, 8'h5a);
    chk("wr_addr", tape_wr_addr_o, 8'h00);
    ev(1, 0, 0, 0, 0, 0);
    ev(0, 1, 0, 0, 0, 0);
    cyc(100);
    chk("ovr", wr_ovr_o, 1'b0);
    str_host_model_inst.push(8'ha5);
    wt(0, 3);
    chk("wr_addr", tape_wr_addr_o, 8'h01);
    ev(1, 0, 0, 0, 0, 0);
    ev(0, 1, 0, 0, 0, 0);
    cyc(200);
    chk("ovr", wr_ovr_o, 1'b0);
    wt(2, 140);
    chk("ovr_time", n > 100, 1'b1);
    wr_active_i = 1'b0;
    $display("gap test done");
  endtask : t_gap
  task automatic t_raw;
    cyc(2);
    wr_active_i = 1'b1;
    str_host_model_inst.push(8'hc3);
    wt(0, 20);
    str_host_model_inst.push(8'h3c);
    ev(1, 0, 0, 0, 0, 0);
    wt(0, 30);
    chk("overlap", {tape_wr_addr_o, tape_wr_data_o}, 16'h013c);
    ev(1, 0, 0, 0, 0, 0);
    ev(0, 1, 1, 0, 0, 0);
    ev(0, 1, 0, 0, 0, 0);
    wt(0, 30);
    chk("rewrite", {tape_wr_addr_o, tape_wr_data_o}, 16'h00c3);
    for (int j = 1; j <= 16; j++) begin
      ev(1, 0, 0, 0, 0, 0);
      ev(0, 1, 1, 0, 0, 0);
      if (j < 16) begin
        wt(0, 30);
        chk("rewrite_addr", tape_wr_addr_o, 8'h00);
      end
    end
    chk("wr_err", wr_err_o, 1'b1);
    wr_active_i = 1'b0;
    $display("rewrite test done");
  endtask : t_raw
  task automatic t_rd;
    rd_active_i = 1'b1;
    cyc(1);
    for (k = 0; k < 40; k++) begin
      ev(0, 0, 0, 1, 0, k[7:0]);
      if (s[1]) break;
    end
    chk("reserve", k, 32);
    str_host_model_inst.pop(d, w);
    chk("rd_data", d, 8'h00);
    wt(1, 10);
    ev(0, 0, 0, 1, 0, 8'h00);
    ev(0, 0, 0, 1, 0, k[7:0]);
    for (int j = 1; j <= k; j++) begin
      str_host_model_inst.pop(d, w);
      chk("rd_data", d, j);
    end
    hang(str_host_model_inst.n >= 99);
    ev(0, 0, 0, 1, 0, k[7:0]);
    chk("dup", host_rd_valid_o, 1'b0);
    for (int j = 0; j < 17; j++) begin
      ev(0, 0, 0, 1, 1, 8'(j < 16 ? k + 1 : 'h77));
      chk("reread", s[0], j < 16);
    end
    chk("rd_err", rd_err_o, 1'b1);
    str_host_model_inst.pop(d, w);
    chk("wrong", {w, d}, 9'h177);
    $display("read test done");
  endtask : t_rd
  task automatic t_stat;
    str_host_model_inst.status;
    hang(str_host_model_inst.n >= 99);
    chk("gap_cnt", str_host_model_inst.sb[0], 8'h02);
    chk("rewrite_cnt", str_host_model_inst.sb[1], 8'h10);
    chk("under_cnt", str_host_model_inst.sb[2], 8'h01);
    chk("retry_cnt", str_host_model_inst.sb[3], 8'h10);
    chk("flags", str_host_model_inst.sb[4], 8'h0e);
    chk("fail_addr", str_host_model_inst.sb[5], 8'h21);
    cyc(2);
    chk("dirc", stat_dirc_o, 1'b0);
    $display("status test done");
  endtask : t_stat
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    num_errors = 0;
    n_tests = 0;
    {rst_i, wr_active_i, rd_active_i} = 3'b100;
    {tape_wr_done_i, tape_raw_i, tape_raw_bad_i} = '0;
    {tape_blk_i, tape_blk_crc_err_i} = '0;
    {tape_blk_data_i, tape_blk_addr_i} = '0;
    cyc(12);
    rst_i = 1'b0;
    t_gap;
    t_raw;
    t_rd;
    t_stat;
    results;
  end
endmodule : str_top_bench
